// [hw/asc_regs.svh]
// Constants of the audio stream and clock command logic: opcodes, field
// positions, reset values, timing figures and host register offsets.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// Opcodes held in bits 3-0 of every command.
`define ASC_OP_STOP        4'h1
`define ASC_OP_DURATION    4'h2
`define ASC_OP_PHRASE      4'h6
`define ASC_OP_ADPCM       4'hA
`define ASC_OP_SET_CLOCK   4'hC
`define ASC_OP_PCM         4'hE
`define ASC_OP_TONE_LOW    2'h3

// Field positions inside a command word.
`define ASC_ADPCM_CLEAR_BIT 4
`define ASC_CLK_DISABLE_BIT 7
`define ASC_CLK_STOP_BIT    6
`define ASC_CLK_DIV_MSB     5
`define ASC_CLK_DIV_LSB     4

// Divisor select codes.
`define ASC_DIV_1          2'h0
`define ASC_DIV_2          2'h1
`define ASC_DIV_4          2'h2
`define ASC_DIV_8          2'h3

// Reset values of the clock output configuration.
`define ASC_CLK_DISABLE_RST 1'h0
`define ASC_CLK_STOP_RST    1'h0
`define ASC_CLK_DIV_RST     2'h3

// Timing: the system clock period and the sample period in ns.
`define ASC_CLK_PERIOD_NS    100
`define ASC_SAMPLE_PERIOD_NS 125000
`define ASC_SAMPLE_CYCLES    (`ASC_SAMPLE_PERIOD_NS / `ASC_CLK_PERIOD_NS)
// Streamed ADPCM silence time, and the same time in sample ticks.
`define ASC_ADPCM_TIMEOUT_NS 250000
`define ASC_ADPCM_TIMEOUT_TICKS (`ASC_ADPCM_TIMEOUT_NS / `ASC_SAMPLE_PERIOD_NS)

// Host controller register offsets and status bits.
`define ASC_REG_CMD        8'h00
`define ASC_REG_SEQ        8'h04
`define ASC_REG_STATUS     8'h08
`define ASC_STAT_BUSY_BIT  0
`define ASC_STAT_SEQ_BIT   1

`endif

// [hw/asc_pkg.sv]
// Types shared by the audio stream and clock command logic.
// Assumes nothing of its surroundings.
package asc_pkg;

   // Phrase engine states.
   typedef enum logic [2:0] {
      ASC_S_IDLE  = 3'h0,
      ASC_S_OP    = 3'h1,
      ASC_S_OPW   = 3'h2,
      ASC_S_ARG   = 3'h3,
      ASC_S_ARGW  = 3'h4,
      ASC_S_EXEC  = 3'h5,
      ASC_S_DATA  = 3'h6,
      ASC_S_DATAW = 3'h7
   } asc_state_t;

endpackage

// [hw/asc_if.sv]
// Command link between the host controller and the playback device.
// Assumes both ends run on the one clock that the interface carries.
`timescale 1ns/10ps
interface asc_if (
   input wire logic clk
);
   logic        cmd_valid;  // One-cycle command strobe from the host.
   logic [15:0] cmd_data;   // Command word, opcode in bits 3-0.
   logic        dev_busy;   // Device is playing ADPCM from memory.

   modport dev (
      input  cmd_valid,
      input  cmd_data,
      output dev_busy
   );

   modport host (
      output cmd_valid,
      output cmd_data,
      input  dev_busy
   );
endinterface

// [hw/asc_adpcm_dec.sv]
// IMA ADPCM nibble decoder with predictor and step index state.
// Assumes nibbles arrive as single-cycle strobes on the device clock.
`timescale 1ns/10ps
module asc_adpcm_dec (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire logic        clear,
   input  wire logic        in_valid,
   input  wire logic [3:0]  nibble,
   output logic             out_valid,
   output logic [15:0]      pred
);
   localparam logic [14:0] STEP [0:88] = '{
      15'h0007, 15'h0008, 15'h0009, 15'h000A, 15'h000B, 15'h000C, 15'h000D, 15'h000E,
      15'h0010, 15'h0011, 15'h0013, 15'h0015, 15'h0017, 15'h0019, 15'h001C, 15'h001F,
      15'h0022, 15'h0025, 15'h0029, 15'h002D, 15'h0032, 15'h0037, 15'h003C, 15'h0042,
      15'h0049, 15'h0050, 15'h0058, 15'h0061, 15'h006B, 15'h0076, 15'h0082, 15'h008F,
      15'h009D, 15'h00AD, 15'h00BE, 15'h00D1, 15'h00E6, 15'h00FD, 15'h0117, 15'h0133,
      15'h0151, 15'h0173, 15'h0198, 15'h01C1, 15'h01EE, 15'h0220, 15'h0256, 15'h0292,
      15'h02D4, 15'h031C, 15'h036C, 15'h03C3, 15'h0424, 15'h048E, 15'h0502, 15'h0583,
      15'h0610, 15'h06AB, 15'h0756, 15'h0812, 15'h08E0, 15'h09C3, 15'h0ABD, 15'h0BD0,
      15'h0CFF, 15'h0E4C, 15'h0FBA, 15'h114C, 15'h1307, 15'h14EE, 15'h1706, 15'h1954,
      15'h1BDC, 15'h1EA5, 15'h21B6, 15'h2515, 15'h28CA, 15'h2CDF, 15'h315B, 15'h364B,
      15'h3BB9, 15'h41B2, 15'h4844, 15'h4F7E, 15'h5771, 15'h602F, 15'h69CE, 15'h7462,
      15'h7FFF};

   logic signed [15:0] pred_q;
   logic        [6:0]  idx;
   logic signed [15:0] base_pred;
   logic        [6:0]  base_idx;
   logic        [14:0] step;
   logic        [16:0] diff;
   logic signed [17:0] sum;
   logic signed [8:0]  idx_sum;
   logic signed [15:0] next_pred;
   logic        [6:0]  next_idx;

   // A clear in the same cycle as a nibble decodes that nibble from zero state.
   always_comb begin
      base_pred = clear ? 16'sh0000 : pred_q;
      base_idx  = clear ? 7'h00 : idx;
      step      = STEP[base_idx];
      diff      = 17'(step >> 3);
      if (nibble[2]) diff = diff + 17'(step);
      if (nibble[1]) diff = diff + 17'(step >> 1);
      if (nibble[0]) diff = diff + 17'(step >> 2);
      sum = nibble[3] ? (18'(base_pred) - 18'(signed'({1'b0, diff})))
                      : (18'(base_pred) + 18'(signed'({1'b0, diff})));
      // Saturate rather than wrap, so a loud burst clips instead of flipping sign.
      if (sum > 18'sh07FFF)       next_pred = 16'sh7FFF;
      else if (sum < -18'sh08000) next_pred = -16'sh8000;
      else                        next_pred = sum[15:0];
      idx_sum = nibble[2] ? 9'(signed'({2'b00, base_idx}) + 9'(2 * nibble[1:0] + 2))
                          : 9'(signed'({2'b00, base_idx}) - 9'sh001);
      if (idx_sum < 9'sh000)      next_idx = 7'h00;
      else if (idx_sum > 9'sh058) next_idx = 7'h58;
      else                        next_idx = idx_sum[6:0];
   end

   // Decoder state, also cleared alone when no nibble comes with the clear.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pred_q    <= 16'sh0000;
         idx       <= 7'h00;
         out_valid <= 1'b0;
      end else if (ce) begin
         out_valid <= in_valid;
         if (in_valid) begin
            pred_q <= next_pred;
            idx    <= next_idx;
         end else if (clear) begin
            pred_q <= 16'sh0000;
            idx    <= 7'h00;
         end
      end
   end

   assign pred = pred_q;
endmodule

// [hw/asc_device.sv]
// Playback device end: executes streamed and phrase commands, decodes
// ADPCM, paces 12-bit samples and drives the divided clock output pin.
// Assumes a host on the command link and an external memory that answers
// each read strobe with one byte and a valid pulse on the same clock.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/10ps
`include "asc_regs.svh"
module asc_device #(
   parameter int SAMPLE_CYCLES = `ASC_SAMPLE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   asc_if.dev               link,
   input  wire logic        phrase_start,
   input  wire logic [23:0] phrase_addr,
   input  wire logic        memory_address_width_select,
   output logic             mem_rd,
   output logic [23:0]      mem_addr,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_rvalid,
   output logic             divided_clock_output_pin,
   output logic             divided_clock_output_pin_oe,
   output logic [11:0]      spk_level,
   output logic             spk_tick,
   output logic             phrase_busy
);
   localparam int TW = $clog2(SAMPLE_CYCLES);

   asc_pkg::asc_state_t state;
   logic [TW-1:0] tick_cnt;
   logic          sample_tick;
   logic          width_meta;
   logic          width_sel;
   logic [31:0]   cmd_buf;
   logic [1:0]    byte_idx;
   logic [2:0]    need;
   logic [23:0]   byte_cnt;
   logic [7:0]    nib_buf;
   logic [1:0]    nib_cnt;
   logic [11:0]   audio_level;
   logic          clk_disable;
   logic          clk_stop;
   logic [1:0]    clk_div;
   logic [2:0]    div_cnt;
   logic          mem_adpcm;
   logic          mem_exec;
   logic          host_take;
   logic          exec_v;
   logic [15:0]   exec_w;
   logic [3:0]    op;
   logic          host_adpcm;
   logic          nib_load;
   logic          dec_feed;
   logic          dec_clear;
   logic          dec_valid;
   logic [15:0]   dec_pred;

   // Command length in bytes inside a phrase, from its opcode.
   function automatic logic [2:0] asc_cmd_len(input logic [3:0] code, input logic wide);
      if (code == `ASC_OP_ADPCM)
         asc_cmd_len = wide ? 3'h4 : 3'h3;
      else if (code == `ASC_OP_PCM || code == `ASC_OP_DURATION ||
               code == `ASC_OP_PHRASE || code[1:0] == `ASC_OP_TONE_LOW)
         asc_cmd_len = 3'h2;
      else
         asc_cmd_len = 3'h1;
   endfunction

   // Divider bit that gives the selected rate.
   function automatic logic asc_div_bit(input logic [1:0] sel, input logic [2:0] cnt);
      case (sel)
         `ASC_DIV_4: asc_div_bit = cnt[1];
         `ASC_DIV_8: asc_div_bit = cnt[2];
         default:    asc_div_bit = cnt[0];
      endcase
   endfunction

   // The width strap is a pin, so it passes two flip-flops first.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         width_meta <= 1'b0;
         width_sel  <= 1'b0;
      end else if (ce) begin
         width_meta <= memory_address_width_select;
         width_sel  <= width_meta;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tick_cnt    <= '0;
         sample_tick <= 1'b0;
      end else if (ce) begin
         sample_tick <= (tick_cnt == TW'(SAMPLE_CYCLES - 1));
         tick_cnt    <= (tick_cnt == TW'(SAMPLE_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
      end
   end

   assign mem_adpcm = (state == asc_pkg::ASC_S_DATA) || (state == asc_pkg::ASC_S_DATAW);
   assign mem_exec  = (state == asc_pkg::ASC_S_EXEC);
   assign host_take = link.cmd_valid && !mem_adpcm && !mem_exec;
   // One execute path for phrase and host commands; the phrase wins a tie.
   assign exec_v    = mem_exec || host_take;
   assign exec_w    = mem_exec ? cmd_buf[15:0] : link.cmd_data;
   assign op        = exec_w[3:0];
   assign host_adpcm = host_take && (op == `ASC_OP_ADPCM);
   assign nib_load   = host_adpcm || ((state == asc_pkg::ASC_S_DATAW) && mem_rvalid);
   assign dec_feed   = sample_tick && (nib_cnt != 2'h0) && !nib_load;
   assign dec_clear  = exec_v && (op == `ASC_OP_ADPCM) && exec_w[`ASC_ADPCM_CLEAR_BIT];

   asc_adpcm_dec u_dec (
      .clk       (clk),
      .nrst      (nrst),
      .ce        (ce),
      .clear     (dec_clear),
      .in_valid  (dec_feed),
      .nibble    (nib_buf[3:0]),
      .out_valid (dec_valid),
      .pred      (dec_pred)
   );

   // Nibble pair: the low nibble goes first, then the buffer shifts down.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         nib_buf <= 8'h00;
         nib_cnt <= 2'h0;
      end else if (ce) begin
         if (host_adpcm) begin
            nib_buf <= exec_w[15:8];
            nib_cnt <= 2'h2;
         end else if (nib_load) begin
            nib_buf <= mem_rdata;
            nib_cnt <= 2'h2;
         end else if (host_take && op == `ASC_OP_STOP) begin
            nib_cnt <= 2'h0;
         end else if (dec_feed) begin
            nib_buf <= nib_buf >> 4;
            nib_cnt <= nib_cnt - 2'h1;
         end
      end
   end

   // Speaker level changes only on a new sample; with no fresh data it holds,
   // which silences a stalled stream and repeats the last raw sample.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         audio_level <= 12'h000;
         spk_level   <= 12'h000;
         spk_tick    <= 1'b0;
      end else if (ce) begin
         if (exec_v && op == `ASC_OP_PCM)
            audio_level <= exec_w[15:4];
         else if (dec_valid)
            audio_level <= dec_pred[15:4];
         spk_tick <= sample_tick;
         if (sample_tick)
            spk_level <= audio_level;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         clk_disable <= `ASC_CLK_DISABLE_RST;
         clk_stop    <= `ASC_CLK_STOP_RST;
         clk_div     <= `ASC_CLK_DIV_RST;
      end else if (ce && exec_v && op == `ASC_OP_SET_CLOCK) begin
         clk_disable <= exec_w[`ASC_CLK_DISABLE_BIT];
         clk_stop    <= exec_w[`ASC_CLK_STOP_BIT];
         clk_div     <= exec_w[`ASC_CLK_DIV_MSB:`ASC_CLK_DIV_LSB];
      end
   end

   // The pin comes from a flop, so divide by one cannot pass the raw clock:
   // it toggles every cycle like divide by two.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         div_cnt                     <= 3'h0;
         divided_clock_output_pin    <= 1'b0;
         divided_clock_output_pin_oe <= 1'b0;
      end else if (ce) begin
         div_cnt <= div_cnt + 3'h1;
         divided_clock_output_pin_oe <= 1'b1;
         divided_clock_output_pin <= clk_disable ? clk_stop
                                                 : asc_div_bit(clk_div, div_cnt + 3'h1);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state         <= asc_pkg::ASC_S_IDLE;
         mem_rd        <= 1'b0;
         mem_addr      <= 24'h000000;
         cmd_buf       <= 32'h00000000;
         byte_idx      <= 2'h0;
         need          <= 3'h0;
         byte_cnt      <= 24'h000000;
         phrase_busy   <= 1'b0;
         link.dev_busy <= 1'b0;
      end else if (ce) begin
         mem_rd <= 1'b0;
         case (state)
            asc_pkg::ASC_S_IDLE: begin
               if (phrase_start) begin
                  mem_addr <= phrase_addr;
                  state    <= asc_pkg::ASC_S_OP;
               end
            end
            asc_pkg::ASC_S_OP: begin
               mem_rd <= 1'b1;
               state  <= asc_pkg::ASC_S_OPW;
            end
            asc_pkg::ASC_S_OPW: begin
               if (mem_rvalid) begin
                  cmd_buf  <= {24'h000000, mem_rdata};
                  mem_addr <= mem_addr + 24'h000001;
                  byte_idx <= 2'h1;
                  need     <= asc_cmd_len(mem_rdata[3:0], width_sel);
                  if (mem_rdata[3:0] == `ASC_OP_STOP)
                     state <= asc_pkg::ASC_S_IDLE;
                  else if (asc_cmd_len(mem_rdata[3:0], width_sel) == 3'h1)
                     state <= asc_pkg::ASC_S_EXEC;
                  else
                     state <= asc_pkg::ASC_S_ARG;
               end
            end
            asc_pkg::ASC_S_ARG: begin
               mem_rd <= 1'b1;
               state  <= asc_pkg::ASC_S_ARGW;
            end
            asc_pkg::ASC_S_ARGW: begin
               if (mem_rvalid) begin
                  cmd_buf[{byte_idx, 3'h0} +: 8] <= mem_rdata;
                  mem_addr <= mem_addr + 24'h000001;
                  byte_idx <= byte_idx + 2'h1;
                  state    <= ({1'b0, byte_idx} + 3'h1 == need) ? asc_pkg::ASC_S_EXEC
                                                                 : asc_pkg::ASC_S_ARG;
               end
            end
            asc_pkg::ASC_S_EXEC: begin
               state <= asc_pkg::ASC_S_OP;
               if (cmd_buf[3:0] == `ASC_OP_ADPCM) begin
                  byte_cnt <= width_sel ? cmd_buf[31:8] : {8'h00, cmd_buf[23:8]};
                  if ((width_sel ? cmd_buf[31:8] : {8'h00, cmd_buf[23:8]}) != 24'h000000)
                     state <= asc_pkg::ASC_S_DATA;
               end
            end
            asc_pkg::ASC_S_DATA: begin
               // Fetch only once both nibbles of the last byte have played.
               if (nib_cnt == 2'h0) begin
                  if (byte_cnt == 24'h000000) begin
                     state <= asc_pkg::ASC_S_OP;
                  end else begin
                     mem_rd <= 1'b1;
                     state  <= asc_pkg::ASC_S_DATAW;
                  end
               end
            end
            asc_pkg::ASC_S_DATAW: begin
               if (mem_rvalid) begin
                  mem_addr <= mem_addr + 24'h000001;
                  byte_cnt <= byte_cnt - 24'h000001;
                  state    <= asc_pkg::ASC_S_DATA;
               end
            end
            default: state <= asc_pkg::ASC_S_IDLE;
         endcase
         // A host stop ends a phrase outside its ADPCM playback and its execute cycle.
         if (host_take && op == `ASC_OP_STOP)
            state <= asc_pkg::ASC_S_IDLE;
         phrase_busy   <= (state != asc_pkg::ASC_S_IDLE);
         link.dev_busy <= mem_adpcm;
      end
   end
endmodule

// [hw/asc_host.sv]
// Host controller end: software writes commands into a register, the
// controller sends them over the link and reports device status.
// Assumes a register port master on the same clock as the link.
`timescale 1ns/10ps
`include "asc_regs.svh"
module asc_host (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   asc_if.host              link,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata
);
   logic        seq_armed;
   logic        cmd_wr;
   logic [15:0] next_cmd;

   assign cmd_wr = wr && (addr == `ASC_REG_CMD);

   always_comb begin
      next_cmd = wdata[15:0];
      if (wdata[3:0] == `ASC_OP_ADPCM)
         next_cmd[`ASC_ADPCM_CLEAR_BIT] = seq_armed;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         link.cmd_valid <= 1'b0;
         link.cmd_data  <= 16'h0000;
      end else if (ce) begin
         link.cmd_valid <= cmd_wr;
         if (cmd_wr)
            link.cmd_data <= next_cmd;
      end
   end

   // Arming is one-shot so software cannot forget to drop the flag later.
   always_ff @(posedge clk) begin
      if (!nrst)
         seq_armed <= 1'b0;
      else if (ce) begin
         if (wr && addr == `ASC_REG_SEQ && wdata[0])
            seq_armed <= 1'b1;
         else if (cmd_wr && wdata[3:0] == `ASC_OP_ADPCM)
            seq_armed <= 1'b0;
      end
   end

   // Read data stand one cycle after the strobe; unmapped offsets read zero.
   always_ff @(posedge clk) begin
      if (!nrst)
         rdata <= 32'h00000000;
      else if (ce) begin
         rdata <= 32'h00000000;
         if (rd) begin
            case (addr)
               `ASC_REG_CMD: rdata <= {16'h0000, link.cmd_data};
               `ASC_REG_SEQ: rdata <= {31'h00000000, seq_armed};
               `ASC_REG_STATUS: begin
                  rdata[`ASC_STAT_BUSY_BIT] <= link.dev_busy;
                  rdata[`ASC_STAT_SEQ_BIT]  <= seq_armed;
               end
               default: rdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// [sim/asc_link_chk.sv]
// Checker for the command link between the host and device ends.
// Assumes one clock and the synchronous active-low reset of both ends.
`timescale 1ns/10ps
module asc_link_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        cmd_valid,
   input wire logic [15:0] cmd_data,
   input wire logic        dev_busy,
   input wire logic [11:0] spk_level,
   input wire logic        spk_tick,
   input wire logic        pin_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // A memory playback run begins where busy rises.
   sequence play_start;
      $rose(dev_busy);
   endsequence

   // One byte spans two sample ticks, so busy cannot blink.
   chk_busy_holds: assert property (play_start |-> dev_busy[*8])
      else $error("busy dropped too early");
   chk_busy_ends: assert property (play_start |-> ##[8:1000] !dev_busy)
      else $error("playback never finished");
   chk_word_strobed: assert property ($changed(cmd_data) |-> cmd_valid)
      else $error("command word changed without strobe");

   // A sample tick is a single-cycle pulse.
   sequence tick_pulse;
      spk_tick ##1 !spk_tick;
   endsequence

   chk_tick_single: assert property (spk_tick |-> tick_pulse)
      else $error("sample tick longer than one cycle");
   // The level moves only at a tick, so a stalled stream holds its last level.
   chk_level_on_tick: assert property ($changed(spk_level) |-> spk_tick)
      else $error("speaker level moved between ticks");
   // The pin driver is on in every cycle after the first one out of reset.
   chk_oe_steady: assert property ($past(nrst) |-> pin_oe)
      else $error("clock pin not driven");
endmodule

// [sim/audio_stream_clock_commands_test.sv]
// Testbench: host and device ends joined by the link, plus a byte memory.
// Assumes a 10 MHz clock and a sample period shortened to 16 cycles.
`timescale 1ns/10ps
module audio_stream_clock_commands_test;
   localparam int              HALF[4] = '{1, 1, 2, 4};
   // The level is the top 12 bits of the 16-bit prediction; the third
   // sequence is not armed, so it carries on from the second one's state.
   localparam logic [15:0]     ADP[3]  = '{16'h771A, 16'h771A, 16'h771A};
   localparam logic [11:0]     E1[3]   = '{12'h000, 12'h000, 12'h006};
   localparam logic [11:0]     E2[3]   = '{12'h002, 12'h002, 12'h00F};
   // Images hold one byte, an even sample count.
   localparam logic [47:0]     NIMG    = 48'h00_01_17_00_01_1A;
   localparam logic [47:0]     WIMG    = 48'h01_17_00_00_01_1A;
   logic        clk = 0, nrst = 0, ce = 1, wr = 0, rd = 0, tick_seen = 0;
   logic        phrase_start = 0, width_sel = 0, mem_rvalid = 0;
   logic [7:0]  addr = 8'h00, mem_rdata = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rng = 32'd47115;
   logic [23:0] phrase_addr = 24'h0, mem_addr;
   logic        mem_rd, pin, pin_oe, spk_tick, phrase_busy;
   logic [11:0] spk_level;
   logic [12:0] note;
   logic [12:0] notes[$];
   logic [7:0]  mem[0:31];
   int          n_errors = 0, check_count = 0;

   asc_if link (.clk(clk));
   asc_host i_asc_host (.clk(clk), .nrst(nrst), .ce(ce), .link(link), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   asc_device #(.SAMPLE_CYCLES(16)) i_asc_device (.clk(clk), .nrst(nrst), .ce(ce),
      .link(link), .phrase_start(phrase_start), .phrase_addr(phrase_addr),
      .memory_address_width_select(width_sel), .mem_rd(mem_rd), .mem_addr(mem_addr),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .divided_clock_output_pin(pin),
      .divided_clock_output_pin_oe(pin_oe), .spk_level(spk_level), .spk_tick(spk_tick),
      .phrase_busy(phrase_busy));
   asc_link_chk i_asc_link_chk (.clk(clk), .nrst(nrst), .cmd_valid(link.cmd_valid),
      .cmd_data(link.cmd_data), .dev_busy(link.dev_busy), .spk_level(spk_level),
      .spk_tick(spk_tick), .pin_oe(pin_oe));

   always #50 clk = ~clk;

   // Memory answers one cycle later; idle data lines wander so nothing stale passes.
   always @(posedge clk) begin
      mem_rvalid <= mem_rd;
      mem_rdata <= mem_rd ? mem[mem_addr[4:0]] : ~mem_rdata;
      tick_seen <= spk_tick;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic expire();
      n_errors++;
      wrap_up();
   endtask

   task automatic cmp_pin(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: pin or flag %b", $time, got);
      end
   endtask

   task automatic cmp_level(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: level %h not %h", $time, got, exp);
      end
   endtask

   // The level is compared one cycle after each tick, once it has settled.
   always @(negedge clk) begin
      if (tick_seen === 1'b1 && notes.size() > 0) begin
         note = notes.pop_front();
         if (!note[12]) cmp_level(spk_level, note[11:0]);
      end
   end

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      cmp_pin(rdata === exp, 1'b1);
   endtask

   task automatic wait_tick();
      int i;
      for (i = 0; i < 100 && spk_tick !== 1'b1; i++) @(posedge clk);
      if (i == 100) expire();
      @(posedge clk);
   endtask

   // Counts cycles between two pin edges; bounded so a stuck pin shows up.
   task automatic half(output int n);
      logic p;
      p = pin;
      for (n = 0; n < 40 && pin === p; n++) @(posedge clk);
      p = pin;
      for (n = 0; n < 40 && pin === p; n++) @(posedge clk);
   endtask

   initial begin
      int i, k, n;
      for (k = 0; k < 6; k++) begin
         mem[k] = NIMG[8*k +: 8];
         mem[16+k] = WIMG[8*k +: 8];
      end
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      cmp_pin(pin_oe, 1'b1);
      half(n);
      cmp_pin(n == 4, 1'b1);
      for (k = 0; k < 4; k++) begin
         reg_write(8'h00, {26'h0, k[1:0], 4'hC});
         repeat (4) @(posedge clk);
         half(n);
         cmp_pin(n == HALF[k], 1'b1);
      end
      for (k = 0; k < 2; k++) begin
         reg_write(8'h00, {24'h0, 1'b1, k[0], 6'h0C});
         repeat (3) @(posedge clk);
         cmp_pin(pin, k[0]);
      end
      $display("test clock output done");
      for (k = 0; k < 3; k++) begin
         wait_tick();
         if (k < 2) reg_write(8'h04, 32'h1);
         reg_write(8'h00, {16'h0, ADP[k]});
         notes.push_back(13'h1000);
         notes.push_back({1'b0, E1[k]});
         repeat (3) notes.push_back({1'b0, E2[k]});
         repeat (5) wait_tick();
      end
      $display("test streamed decode done");
      for (k = 0; k < 3; k++) begin
         rng = xs(rng);
         wait_tick();
         reg_write(8'h00, {16'h0, rng[11:0], 4'hE});
         repeat (2) notes.push_back({1'b0, rng[11:0]});
         repeat (2) wait_tick();
      end
      $display("test raw samples done");
      for (k = 0; k < 2; k++) begin
         width_sel <= k[0];
         phrase_addr <= k[0] ? 24'h10 : 24'h0;
         repeat (3) @(posedge clk);
         phrase_start <= 1'b1;
         @(posedge clk);
         phrase_start <= 1'b0;
         for (i = 0; i < 100 && link.dev_busy !== 1'b1; i++) @(posedge clk);
         if (i == 100) expire();
         reg_write(8'h00, 32'h7FFE);
         reg_read(8'h08, 32'h1);
         for (i = 0; i < 400 && phrase_busy === 1'b1; i++) @(posedge clk);
         if (i == 400) expire();
         repeat (2) wait_tick();
         repeat (2) notes.push_back(13'h001);
         repeat (2) wait_tick();
      end
      reg_read(8'hFC, 32'h0);
      $display("test memory phrases done");
      wrap_up();
   end
endmodule
